/* File: dv/adc_descriptor_dma_engine_tb.sv */
`timescale 1ns/1ns
// ---------------------------------------------------------------
// two channels: driver notes beats, monitor compares them
// ---------------------------------------------------------------
module adc_descriptor_dma_engine_tb
  import ade_pkg::*;
;
  typedef struct packed {
    logic        wrap;
    logic [31:0] addr;
    logic [15:0] len;
  } ade_win_type;
  logic             ref_clk = 1'b0;
  logic             rstn = 1'b1;
  logic             ce = 1'b1;
  logic             hsel = 1'b0;
  logic             hwrite = 1'b0;
  logic [1:0]       htrans = 2'b00;
  logic [31:0]      haddr = 32'h0;
  logic [31:0]      hwdata = 32'h0;
  logic [1:0]       smp_valid = 2'b00;
  logic [1:0][15:0] smp_data = '0;
  logic [31:0]      hrdata, rd;
  logic [1:0]       smp_ready, irq_req;
  logic             hready, hreadyout, hresp, tx_valid, tx_ready, tx_last;
  logic             tx_resp_valid, tx_resp_retry;
  ade_hdr_type      tx_hdr;
  logic [15:0]      tx_data;
  logic [54:0]      expq[2][$];
  ade_win_type      wq[2][$];
  int               mismatches = 0, tests_run = 0, cur = 0, tot[2], pos[2], n[2], k;
  int               ok_chan[$];
  always #5 ref_clk = ~ref_clk;
  assign hready = hreadyout;
  ade_dma_engine #(.NCH(2)) i_dut (
    .ref_clk(ref_clk), .rstn(rstn), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .smp_valid(smp_valid),
    .smp_data(smp_data), .smp_ready(smp_ready), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .tx_hdr(tx_hdr), .tx_data(tx_data), .tx_last(tx_last), .tx_resp_valid(tx_resp_valid),
    .tx_resp_retry(tx_resp_retry), .irq_req(irq_req));
  ade_host_model i_host (.ref_clk(ref_clk), .rstn(rstn), .ce(ce), .tx_valid(tx_valid),
    .tx_last(tx_last), .tx_ready(tx_ready), .tx_resp_valid(tx_resp_valid),
    .tx_resp_retry(tx_resp_retry));
  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [63:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: saw %0h want %0h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    $display("checks %0d, mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic tmo();
    mismatches++;
    summarize();
  endtask
  // waits up to 64 bus edges for one that sees hready high
  task automatic rdy();
    int j;
    j = 0;
    do begin
      @(posedge ref_clk);
      j++;
    end while (hready !== 1'b1 && j < 64);
    if (hready !== 1'b1) tmo();
  endtask
  task automatic ahb(input logic w, input logic [31:0] a, d);
    @(posedge ref_clk);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= a;
    hwrite <= w;
    rdy();
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    rdy();
    rd = hrdata;
  endtask
  task automatic wr(input logic [31:0] a, d);
    ahb(1'b1, a, d);
  endtask
  task automatic rdc(input logic [31:0] a, exp);
    ahb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  // descriptor: marker, flags and link, then host address and length
  task automatic desc(input int i, input logic lst, irq, wrap, input logic [10:0] nx,
                      input logic [31:0] ad, ln);
    logic [31:0] w;
    w = {DESC_MARK, 28'h0};
    w[W0_LAST_BIT] = lst;
    w[W0_IRQ_BIT] = irq;
    w[W0_WRAP_BIT] = wrap;
    w[W0_NEXT_MSB:0] = nx;
    wr(32'h2000 + 32'(i * 4), w);
    wr(32'h2004 + 32'(i * 4), ad);
    wr(32'h2008 + 32'(i * 4), ln);
  endtask
  task automatic wait_tot(input int c, v);
    for (k = 0; k < 20000 && tot[c] < v; k++) @(posedge ref_clk);
    if (tot[c] < v) tmo();
  endtask
  // ---------------------------------------------------------------
  // sample driver: every accepted sample becomes an expected beat
  // ---------------------------------------------------------------
  always @(posedge ref_clk) begin
    ade_win_type wn;
    int          s;
    for (int c = 0; c < 2; c++) begin
      if (smp_valid[c] && smp_ready[c] === 1'b1) begin
        if (wq[c].size() == 0) begin
          chk(1, 0);
        end else begin
          wn = wq[c][0];
          s = n[c] / PKT_SMP * PKT_SMP;
          if (c == 0 && tot[0] == 130) chk(irq_req[0], 0);
          expq[c].push_back({wn.addr + 32'(2 * s), 7'(int'(wn.len) - s > PKT_SMP ?
                             PKT_SMP : int'(wn.len) - s), smp_data[c]});
          n[c]++;
          if (n[c] == int'(wn.len)) begin
            n[c] = 0;
            if (!wn.wrap) void'(wq[c].pop_front());
          end
        end
        tot[c]++;
        smp_data[c] <= 16'($urandom);
      end
    end
  end
  // monitor: a packet's notes leave the queue only when answered ok
  always @(posedge ref_clk) begin
    if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
      cur = int'(tx_hdr.chan[0]);
      if (pos[cur] < expq[cur].size()) begin
        chk({tx_hdr.addr, tx_hdr.len, tx_data}, expq[cur][pos[cur]]);
      end else begin
        chk(1, 0);
      end
      pos[cur]++;
    end
    if (tx_resp_valid === 1'b1 && ce) begin
      if (tx_resp_retry === 1'b0) begin
        repeat (pos[cur]) void'(expq[cur].pop_front());
        ok_chan.push_back(cur);
      end
      pos[cur] = 0;
    end
  end
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    rstn <= 1'b0;  // falling edge at time zero resets every flop except the descriptor memory, its read registers and the sample buffers
    void'($urandom(25));
    repeat (8) @(posedge ref_clk);
    rstn <= 1'b1;
    repeat (4) @(posedge ref_clk);
    rdc(32'h00, 32'h0);
    rdc(32'h14, {21'h0, BASE_RST});
    rdc(32'h08, 32'h0);
    wr(32'h1F0, 32'hFFFF_FFFF);
    rdc(32'h1F0, 32'h0);
    desc(0, 1'b0, 1'b0, 1'b0, 11'd3, 32'h1000_0000, 32'd130);
    desc(3, 1'b1, 1'b1, 1'b0, 11'd0, 32'h2000_0000, 32'd5);
    desc(6, 1'b0, 1'b0, 1'b1, 11'd9, 32'h3000_0000, 32'd200);
    wr(32'h2024, 32'h0);
    desc(12, 1'b1, 1'b0, 1'b0, 11'd0, 32'h4000_0000, 32'd3);
    wq[0].push_back({1'b0, 32'h1000_0000, 16'd130});
    wq[0].push_back({1'b0, 32'h2000_0000, 16'd5});
    wq[1].push_back({1'b1, 32'h3000_0000, 16'd200});
    wr(32'h14, 32'h6);
    wr(32'h00, 32'h1);
    wr(32'h10, 32'h1);
    smp_valid <= 2'b11;
    wr(32'h200, 32'h3);
    $display("test setup done");
    // a short freeze while both channels stream
    repeat (150) @(posedge ref_clk);
    ce <= 1'b0;
    repeat (10) @(posedge ref_clk);
    ce <= 1'b1;
    wait_tot(1, 270);
    wr(32'h10, 32'h0);
    wait_tot(1, 328);
    repeat (200) @(posedge ref_clk);
    chk(tot[1], 328);
    rdc(32'h1C, 32'd128);
    $display("test stop done");
    for (k = 0; k < 20000 && irq_req[0] !== 1'b1; k++) @(posedge ref_clk);
    chk(irq_req[0], 1);
    if (irq_req[0] !== 1'b1) tmo();
    rdc(32'h08, 32'h3);
    wr(32'h08, 32'h1);
    rdc(32'h08, 32'h2);
    chk(irq_req[0], 0);
    $display("test irq done");
    wr(32'h10, 32'h2);
    rdc(32'h18, 32'h0);
    rdc(32'h1C, 32'h0);
    wq[1].delete();
    wq[1].push_back({1'b0, 32'h4000_0000, 16'd3});
    n[1] = 0;
    wr(32'h14, 32'd12);
    wr(32'h10, 32'h1);
    wait_tot(1, 331);
    repeat (200) @(posedge ref_clk);
    rdc(32'h18, 32'h2);
    chk(irq_req[1], 0);
    $display("test reload done");
    // unmarked descriptor must stall the channel
    wr(32'h00, 32'h0);
    wr(32'h04, 32'h9);
    wr(32'h00, 32'h2);
    // the refetch after the reset needs a few cycles to flag the marker
    repeat (8) @(posedge ref_clk);
    rdc(32'h08, 32'h4);
    wr(32'h00, 32'h1);
    repeat (200) @(posedge ref_clk);
    chk(expq[0].size() + expq[1].size(), 0);
    chk(ok_chan.size() >= 2, 1);
    chk(ok_chan[0], 0);
    chk(ok_chan[1], 1);
    $display("test marker done");
    summarize();
  end
endmodule

/* File: dv/ade_dma_engine_props.sv */
`timescale 1ns/1ns
// ---------------------------------------------------------------
// port checks on the packet sender, the register bus and reset
// ---------------------------------------------------------------
module ade_dma_engine_props
  import ade_pkg::*;
#(
  parameter int NCH = 8
) (
  input wire logic           ref_clk,
  input wire logic           rstn,
  input wire logic           ce,
  input wire logic           hreadyout,
  input wire logic [31:0]    hrdata,
  input wire logic           hresp,
  input wire logic [NCH-1:0] smp_ready,
  input wire logic           tx_valid,
  input wire logic           tx_ready,
  input wire ade_hdr_type    tx_hdr,
  input wire logic [15:0]    tx_data,
  input wire logic           tx_last,
  input wire logic           tx_resp_valid,
  input wire logic           tx_resp_retry,
  input wire logic [NCH-1:0] irq_req
);
  logic [6:0]  beat_cnt;
  logic        retry_pend;
  ade_hdr_type last_hdr;
  // beat index; assumes no channel reset while a packet is on the wire
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      beat_cnt <= 7'h00;
    end else if (tx_valid && tx_ready) begin
      beat_cnt <= tx_last ? 7'h00 : beat_cnt + 7'h01;
    end
  end
  // header of the packet a retry must resend
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      retry_pend <= 1'b0;
      last_hdr   <= '0;
    end else begin
      if (tx_valid && tx_ready && tx_last) last_hdr <= tx_hdr;
      if (tx_resp_valid && tx_resp_retry) retry_pend <= 1'b1;
      else if (tx_valid) retry_pend <= 1'b0;
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  hold_beat_a: assert property (
    tx_valid && !tx_ready |=> !ce || (tx_valid && $stable(tx_hdr) && $stable(tx_data)))
    else $error("beat changed before it was taken");
  same_hdr_a: assert property (
    tx_valid && tx_ready && !tx_last |=> !ce || (tx_valid && $stable(tx_hdr)))
    else $error("header changed inside a packet");
  len_range_a: assert property (
    tx_valid |-> tx_hdr.len != 7'd0 && tx_hdr.len <= 7'd64)
    else $error("packet length out of range");
  last_beat_a: assert property (
    tx_valid |-> tx_last == (beat_cnt == tx_hdr.len - 7'd1))
    else $error("last beat flag misplaced");
  resp_gap_a: assert property (
    tx_valid && tx_ready && tx_last |=> !tx_valid)
    else $error("sender did not wait for the answer");
  retry_same_a: assert property (
    retry_pend && tx_valid |-> tx_hdr == last_hdr)
    else $error("retry did not resend the same packet");
  chan_range_a: assert property (
    tx_valid |-> tx_hdr.chan < NCH)
    else $error("channel number out of range");
  reset_quiet_a: assert property (disable iff (1'b0)
    !rstn |-> !tx_valid && smp_ready == '0 && irq_req == '0 && hrdata == 32'h0)
    else $error("outputs active during reset");
  bus_okay_a: assert property (hreadyout && !hresp)
    else $error("register bus not ready or not okay");
  cover property (tx_resp_valid && tx_resp_retry);
  cover property (tx_valid && tx_ready && tx_last && tx_hdr.len < 7'd64);
  cover property ($rose(irq_req[0]));
endmodule

bind ade_dma_engine ade_dma_engine_props #(.NCH(NCH)) i_props (
  .ref_clk(ref_clk), .rstn(rstn), .ce(ce), .hreadyout(hreadyout), .hrdata(hrdata),
  .hresp(hresp), .smp_ready(smp_ready), .tx_valid(tx_valid), .tx_ready(tx_ready),
  .tx_hdr(tx_hdr), .tx_data(tx_data), .tx_last(tx_last), .tx_resp_valid(tx_resp_valid),
  .tx_resp_retry(tx_resp_retry), .irq_req(irq_req));

/* File: dv/ade_host_model.sv */
`timescale 1ns/1ns
// ---------------------------------------------------------------
// host side: random stalls, one answer per packet, first one retried
// ---------------------------------------------------------------
module ade_host_model (
  input  wire logic ref_clk,
  input  wire logic rstn,
  input  wire logic ce,
  input  wire logic tx_valid,
  input  wire logic tx_last,
  output logic      tx_ready,
  output logic      tx_resp_valid,
  output logic      tx_resp_retry
);
  logic used_r;
  logic fin;
  assign fin = tx_valid && tx_ready && tx_last;
  // retry flag is noise unless the answer is valid
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      tx_ready      <= 1'b0;
      tx_resp_valid <= 1'b0;
      tx_resp_retry <= 1'b0;
      used_r        <= 1'b0;
    end else if (ce) begin  // frozen with the engine so no answer is lost
      tx_ready      <= ($urandom % 4) != 0;
      tx_resp_valid <= fin;
      tx_resp_retry <= fin ? !used_r : 1'($urandom);
      if (fin) used_r <= 1'b1;
    end
  end
endmodule

/* File: src/ade_dma_engine.sv */
`timescale 1ns/1ns
// Function
// - first fetch from base after activation or reset
// - base write while enabled reloads descriptor
// - consecutive packets, next descriptor when window full
// - interrupts only from descriptor request flag
// - after final descriptor, successor still loaded
// - per-channel fill level readable by software
// - round robin grant from channel zero
// - skip channels without a ready packet
// - 64-sample packets, short last packet
// - descriptor is three consecutive words
// - word0 marker 0xC, else descriptor unused
// - chain end flag stops channel
// - irq request flag raises interrupt
// - wrap flag fetches base next
// - bits 10:0 give next descriptor address
// - word1 host address, word2 sample length
// - endpoint reset clears state and interrupts
// - built packet held for burst and retry
// - transfer enable off finishes current packet
// - channel reset aborts and reloads base
module ade_dma_engine
  import ade_pkg::*;
#(
  parameter int NCH = 8
) (
  input  wire logic                   ref_clk,
  input  wire logic                   rstn,
  input  wire logic                   ce,
  input  wire logic                   hsel,
  input  wire logic [31:0]            haddr,
  input  wire logic [1:0]             htrans,
  input  wire logic                   hwrite,
  input  wire logic [2:0]             hsize,
  input  wire logic [31:0]            hwdata,
  input  wire logic                   hready,
  output logic                        hreadyout,
  output logic [31:0]                 hrdata,
  output logic                        hresp,
  input  wire logic [NCH-1:0]         smp_valid,
  input  wire logic [NCH-1:0][15:0]   smp_data,
  output logic [NCH-1:0]              smp_ready,
  output logic                        tx_valid,
  input  wire logic                   tx_ready,
  output ade_hdr_type                 tx_hdr,
  output logic [15:0]                 tx_data,
  output logic                        tx_last,
  input  wire logic                   tx_resp_valid,
  input  wire logic                   tx_resp_retry,
  output logic [NCH-1:0]              irq_req
);
  localparam int CW = (NCH > 1) ? $clog2(NCH) : 1;

  // ---------------------------------------------------------------
  // reset release
  // ---------------------------------------------------------------
  logic rst_meta_r, rst_n_r;
  // async assert, two-flop release
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rst_meta_r <= 1'b0;
      rst_n_r    <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n_r    <= rst_meta_r;
    end
  end

  // ---------------------------------------------------------------
  // ahb-lite slave
  // ---------------------------------------------------------------
  logic           aw_r, rdesc_r, ap, a_reg, gen_we, desc_we;
  logic [15:0]    aa_r;
  logic [31:0]    hrdata_r, ram_q2;
  logic [3:0]     ach;
  logic [NCH-1:0] cfg_we, base_we, stat_we;

  assign ap        = hsel & htrans[1] & hready;
  assign hreadyout = 1'b1;   // zero wait states
  assign hresp     = 1'b0;
  assign hrdata    = rdesc_r ? ram_q2 : hrdata_r;
  assign ach       = aa_r[7:4];
  assign a_reg     = aw_r & (aa_r[15:8] == 8'h00) & (32'(ach) < NCH);
  assign gen_we    = aw_r & (aa_r == OFS_GEN);
  assign desc_we   = aw_r & aa_r[DESC_SPACE_BIT];

  // write strobes decoded in the data phase
  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      cfg_we[c]  = a_reg & (ach == 4'(c)) & (aa_r[3:0] == OFS_CFG);
      base_we[c] = a_reg & (ach == 4'(c)) & (aa_r[3:0] == OFS_BASE);
      stat_we[c] = a_reg & (ach == 4'(c)) & (aa_r[3:0] == OFS_STAT);
    end
  end

  // ---------------------------------------------------------------
  // per-channel state
  // ---------------------------------------------------------------
  logic [NCH-1:0] ten_r, gen_r, ld_r, dv_r, full_r, done_r, irq_r, bad_r;
  logic [NCH-1:0] hi_r, lf_r, wr_r;
  logic [10:0]    base_r [NCH];
  logic [10:0]    ptr_r  [NCH];
  logic [10:0]    nxt_r  [NCH];
  logic [31:0]    ha_r   [NCH];
  logic [31:0]    rem_r  [NCH];
  logic [31:0]    fill_r [NCH];
  logic [6:0]     cnt_r  [NCH];
  logic [15:0]    buf_r  [NCH][PKT_SMP];
  logic [6:0]     plen   [NCH];
  logic [NCH-1:0] restart, chrst, cmp;

  // address-phase read mux, registered for the data phase
  always_ff @(posedge ref_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      aw_r     <= 1'b0;
      rdesc_r  <= 1'b0;
      aa_r     <= 16'h0000;
      hrdata_r <= 32'h0000_0000;
    end else if (ce) begin
      aw_r    <= ap & hwrite;
      rdesc_r <= ap & ~hwrite & haddr[DESC_SPACE_BIT];
      aa_r    <= haddr[15:0];
      hrdata_r <= 32'h0000_0000;   // unmapped reads as zero
      if (ap && !hwrite) begin
        if (haddr[15:0] == OFS_GEN) begin
          hrdata_r <= 32'(gen_r);
        end
        for (int c = 0; c < NCH; c++) begin
          if (haddr[15:8] == 8'h00 && haddr[7:4] == 4'(c)) begin
            unique case (haddr[3:0])
              OFS_CFG:  hrdata_r <= {31'h0, ten_r[c]};
              OFS_BASE: hrdata_r <= {21'h0, base_r[c]};
              OFS_STAT: hrdata_r <= {29'h0, bad_r[c], done_r[c], irq_r[c]};
              OFS_FILL: hrdata_r <= fill_r[c];
              default:  hrdata_r <= 32'h0000_0000;
            endcase
          end
        end
      end
    end
  end

  // software configuration
  always_ff @(posedge ref_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      ten_r <= '0;
      gen_r <= '0;
      for (int c = 0; c < NCH; c++) base_r[c] <= BASE_RST;
    end else if (ce) begin
      if (gen_we) gen_r <= hwdata[NCH-1:0];
      for (int c = 0; c < NCH; c++) begin
        if (cfg_we[c]) ten_r[c] <= hwdata[CFG_TEN_BIT];
        if (base_we[c]) base_r[c] <= hwdata[10:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // descriptor memory and fetcher
  // ---------------------------------------------------------------
  logic [31:0]        desc_mem [DESC_NW];
  logic [31:0]        ram_q;
  logic [DESC_AW-1:0] raddr;
  ade_fst_type        fst_r;
  logic [CW-1:0]      fch_r;
  logic [10:0]        fptr_r;
  logic [31:0]        fw0_r, fw1_r;
  logic               f_any;
  logic [CW-1:0]      f_pick;
  logic               f_done, f_bad;

  // lowest channel waiting for a descriptor
  always_comb begin
    f_any  = 1'b0;
    f_pick = '0;
    for (int c = NCH - 1; c >= 0; c--) begin
      if (ld_r[c] && gen_r[c] && !restart[c]) begin
        f_any  = 1'b1;
        f_pick = CW'(c);
      end
    end
  end

  always_comb begin
    unique case (fst_r)
      F_IDLE:  raddr = ptr_r[f_pick];
      F_W0:    raddr = fptr_r + 11'h001;
      default: raddr = fptr_r + 11'h002;
    endcase
  end

  // two read ports: fetcher and bus; descriptors have no reset
  always_ff @(posedge ref_clk) begin
    if (ce) begin
      if (desc_we) desc_mem[aa_r[12:2]] <= hwdata;
      ram_q  <= desc_mem[raddr];
      ram_q2 <= desc_mem[haddr[12:2]];
    end
  end

  assign f_bad  = (fst_r == F_W0) & (ram_q[31:W0_MARK_LSB] != DESC_MARK);
  assign f_done = (fst_r == F_W2) & ~restart[fch_r];

  // three-word read sequence; aborted by channel restart
  always_ff @(posedge ref_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      fst_r  <= F_IDLE;
      fch_r  <= '0;
      fptr_r <= 11'h000;
      fw0_r  <= 32'h0000_0000;
      fw1_r  <= 32'h0000_0000;
    end else if (ce) begin
      unique case (fst_r)
        F_IDLE: begin
          if (f_any) begin
            fch_r  <= f_pick;
            fptr_r <= ptr_r[f_pick];
            fst_r  <= F_W0;
          end
        end
        F_W0: begin
          fw0_r <= ram_q;
          fst_r <= (f_bad || restart[fch_r]) ? F_IDLE : F_W1;
        end
        F_W1: begin
          fw1_r <= ram_q;
          fst_r <= restart[fch_r] ? F_IDLE : F_W2;
        end
        F_W2: fst_r <= F_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // transmit arbiter and sender
  // ---------------------------------------------------------------
  ade_sst_type   sst_r;
  logic [CW-1:0] gch_r;
  logic [CW-1:0] rr_r;
  logic [6:0]    idx_r;
  logic          s_any, s_ok;
  logic [CW-1:0] s_pick;

  // first full channel at or after the rotating pointer
  always_comb begin
    s_any  = 1'b0;
    s_pick = '0;
    for (int k = NCH - 1; k >= 0; k--) begin
      if (full_r[(32'(rr_r) + k) % NCH]) begin
        s_any  = 1'b1;
        s_pick = CW'((32'(rr_r) + k) % NCH);
      end
    end
  end

  assign tx_valid = ce & (sst_r == S_DATA);
  assign tx_data  = buf_r[gch_r][idx_r[5:0]];
  assign tx_last  = (idx_r + 7'h01 == plen[gch_r]);
  assign tx_hdr   = '{chan: 4'(gch_r), addr: ha_r[gch_r], len: plen[gch_r]};
  assign s_ok     = (sst_r == S_RESP) & tx_resp_valid & ~tx_resp_retry;

  always_ff @(posedge ref_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      sst_r <= S_IDLE;
      gch_r <= '0;
      rr_r  <= '0;
      idx_r <= 7'h00;
    end else if (ce) begin
      unique case (sst_r)
        S_IDLE: begin
          if (s_any) begin
            gch_r <= s_pick;
            rr_r  <= CW'((32'(s_pick) + 1) % NCH);
            idx_r <= 7'h00;
            sst_r <= S_DATA;
          end
        end
        S_DATA: begin
          if (restart[gch_r]) begin
            sst_r <= S_IDLE;
          end else if (tx_ready) begin
            idx_r <= idx_r + 7'h01;
            if (tx_last) sst_r <= S_RESP;
          end
        end
        S_RESP: begin
          if (restart[gch_r]) begin
            sst_r <= S_IDLE;
          end else if (tx_resp_valid) begin
            idx_r <= 7'h00;
            // buffer kept intact so a retry replays it
            sst_r <= tx_resp_retry ? S_DATA : S_IDLE;
          end
        end
        default: sst_r <= S_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // packet fill and window progress
  // ---------------------------------------------------------------
  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      plen[c] = (rem_r[c] >= 32'(PKT_SMP)) ? 7'(PKT_SMP) : rem_r[c][6:0];
      chrst[c] = cfg_we[c] & hwdata[CFG_RST_BIT];
      restart[c] = ~gen_r[c] | chrst[c] | (base_we[c] & gen_r[c]);
      // started packet completes even if transfer enable drops
      smp_ready[c] = ce & gen_r[c] & dv_r[c] & ~full_r[c] & ~done_r[c]
                   & (rem_r[c] != 32'h0) & (ten_r[c] | (cnt_r[c] != 7'h00));
      cmp[c] = dv_r[c] & ~done_r[c] &
               ((s_ok & (gch_r == CW'(c)) & (rem_r[c] == 32'(plen[c])))
               | (~full_r[c] & (cnt_r[c] == 7'h00) & (rem_r[c] == 32'h0)));
      irq_req[c] = irq_r[c];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      ld_r <= '0;
      dv_r <= '0;
      full_r <= '0;
      done_r <= '0;
      irq_r <= '0;
      bad_r <= '0;
      hi_r <= '0;
      lf_r <= '0;
      wr_r <= '0;
      for (int c = 0; c < NCH; c++) begin
        ptr_r[c]  <= BASE_RST;
        nxt_r[c]  <= 11'h000;
        ha_r[c]   <= 32'h0000_0000;
        rem_r[c]  <= 32'h0000_0000;
        fill_r[c] <= 32'h0000_0000;
        cnt_r[c]  <= 7'h00;
      end
    end else if (ce) begin
      for (int c = 0; c < NCH; c++) begin
        // ack clears first so a same-cycle set wins
        if (stat_we[c] && hwdata[ST_IRQ_BIT]) irq_r[c] <= 1'b0;
        if (restart[c]) begin
          ld_r[c]   <= 1'b1;
          ptr_r[c]  <= base_we[c] ? hwdata[10:0] : base_r[c];
          dv_r[c]   <= 1'b0;
          full_r[c] <= 1'b0;
          done_r[c] <= 1'b0;
          cnt_r[c]  <= 7'h00;
          fill_r[c] <= 32'h0000_0000;
          if (chrst[c]) begin
            irq_r[c] <= 1'b0;
            bad_r[c] <= 1'b0;
          end
        end else begin
          if (f_bad && fch_r == CW'(c)) begin
            ld_r[c]  <= 1'b0;
            bad_r[c] <= 1'b1;
          end
          if (f_done && fch_r == CW'(c)) begin
            ld_r[c]   <= 1'b0;
            dv_r[c]   <= 1'b1;
            lf_r[c]   <= fw0_r[W0_LAST_BIT];
            hi_r[c]   <= fw0_r[W0_IRQ_BIT];
            wr_r[c]   <= fw0_r[W0_WRAP_BIT];
            nxt_r[c]  <= fw0_r[W0_NEXT_MSB:0];
            ha_r[c]   <= fw1_r;
            rem_r[c]  <= ram_q;
            fill_r[c] <= 32'h0000_0000;
          end
          if (smp_ready[c] && smp_valid[c]) begin
            buf_r[c][cnt_r[c][5:0]] <= smp_data[c];
            cnt_r[c] <= cnt_r[c] + 7'h01;
            if (cnt_r[c] + 7'h01 == plen[c]) full_r[c] <= 1'b1;
          end
          if (s_ok && gch_r == CW'(c)) begin
            full_r[c] <= 1'b0;
            cnt_r[c]  <= 7'h00;
            ha_r[c]   <= ha_r[c] + {24'h0, plen[c], 1'b0};
            rem_r[c]  <= rem_r[c] - 32'(plen[c]);
            fill_r[c] <= fill_r[c] + 32'(plen[c]);
          end
          if (cmp[c]) begin
            dv_r[c]  <= 1'b0;
            ld_r[c]  <= 1'b1;
            ptr_r[c] <= wr_r[c] ? base_r[c] : nxt_r[c];
            if (hi_r[c]) irq_r[c] <= 1'b1;
            if (lf_r[c]) done_r[c] <= 1'b1;
          end
        end
      end
    end
  end

endmodule

/* File: src/ade_pkg.sv */
package ade_pkg;
  // ---------------------------------------------------------------
  // sizing
  // ---------------------------------------------------------------
  localparam int PKT_SMP  = 64;      // samples per full packet
  localparam int DESC_AW  = 11;      // descriptor word address bits
  localparam int DESC_NW  = 2048;    // descriptor words
  // ---------------------------------------------------------------
  // descriptor word 0 layout
  // ---------------------------------------------------------------
  localparam logic [3:0] DESC_MARK = 4'hC;
  localparam int W0_MARK_LSB = 28;
  localparam int W0_LAST_BIT = 23;
  localparam int W0_IRQ_BIT  = 21;
  localparam int W0_WRAP_BIT = 20;
  localparam int W0_NEXT_MSB = 10;
  // ---------------------------------------------------------------
  // register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [3:0]  OFS_CFG  = 4'h0;
  localparam logic [3:0]  OFS_BASE = 4'h4;
  localparam logic [3:0]  OFS_STAT = 4'h8;
  localparam logic [3:0]  OFS_FILL = 4'hC;
  localparam logic [15:0] OFS_GEN  = 16'h0200;
  localparam int DESC_SPACE_BIT = 13; // 0x2000..0x3FFF
  localparam int CFG_TEN_BIT = 0;
  localparam int CFG_RST_BIT = 1;
  localparam int ST_IRQ_BIT  = 0;
  localparam int ST_DONE_BIT = 1;
  localparam int ST_BAD_BIT  = 2;
  localparam logic [10:0] BASE_RST = 11'h000;
  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [3:0]  chan;
    logic [31:0] addr;
    logic [6:0]  len;
  } ade_hdr_type;
  typedef enum logic [1:0] {
    F_IDLE = 2'b00, F_W0 = 2'b01, F_W1 = 2'b10, F_W2 = 2'b11
  } ade_fst_type;
  typedef enum logic [1:0] {
    S_IDLE = 2'b00, S_DATA = 2'b01, S_RESP = 2'b10
  } ade_sst_type;
endpackage
